// File: src/cbs_pkg.sv
package cbs_pkg;

    // instruction classes the sequencer knows
    typedef enum logic [3:0] {
        CLS_STORE16_EXT = 4'h0, // store_stack_pointer_op / store_index_op
        CLS_CALL_EXT = 4'h1, // call_subroutine_op, extended
        CLS_INHERENT2 = 4'h2,
        CLS_PULL = 4'h3, // stack_pull_op
        CLS_RET_SUB = 4'h4,
        CLS_WAIT = 4'h5, // wait_interrupt_op
        CLS_RET_INT = 4'h6, // interrupt_return_op
        CLS_SW_TRAP = 4'h7, // software_trap_op
        CLS_BRANCH = 4'h8,
        CLS_BR_CALL = 4'h9, // branch_call_op
        CLS_RMW_EXT = 4'hA, // modify ops incl. test_operand_op
        CLS_IRQ = 4'hB, // hardware interrupt entry
        CLS_IRQ_SHORT = 4'hC // entry after a wait, registers stacked
    } cbs_class_t;

    // where a bus address is taken from
    typedef enum logic [2:0] {
        BASE_OPCODE = 3'h0,
        BASE_OPERAND = 3'h1,
        BASE_STACK = 3'h2,
        BASE_BRANCH = 3'h3,
        BASE_SWI_VEC = 3'h4,
        BASE_IRQ_VEC = 3'h5
    } cbs_base_t;

    // which byte the core must place on the data bus in a write cycle
    typedef enum logic [3:0] {
        SRC_NONE = 4'h0,
        SRC_RET_LO = 4'h1,
        SRC_RET_HI = 4'h2,
        SRC_IDX_LO = 4'h3,
        SRC_IDX_HI = 4'h4,
        SRC_ACC_A = 4'h5,
        SRC_ACC_B = 4'h6,
        SRC_CCR = 4'h7,
        SRC_REG_HI = 4'h8,
        SRC_REG_LO = 4'h9,
        SRC_NEW_OPERAND = 4'hA
    } cbs_src_t;

    // one bus cycle as the table describes it
    typedef struct packed {
        logic valid_address_strobe;
        logic readNotWrite;
        cbs_base_t base;
        logic down; // subtract offset instead of adding
        logic [3:0] offset;
        cbs_src_t src;
        logic take; // read data is meaningful
    } cbs_cycle_t;

    // operand addresses handed over by the core
    typedef struct packed {
        logic [15:0] opcodeAddr;
        logic [15:0] operandAddr;
        logic [15:0] stackPtr;
        logic [15:0] branchAddr;
    } cbs_addrs_t;

    localparam logic [3:0] LEN_STORE16_EXT = 4'h6;
    localparam logic [3:0] LEN_CALL_EXT = 4'h9;
    localparam logic [3:0] LEN_INHERENT2 = 4'h2;
    localparam logic [3:0] LEN_PULL = 4'h4;
    localparam logic [3:0] LEN_RET_SUB = 4'h5;
    localparam logic [3:0] LEN_WAIT = 4'h9;
    localparam logic [3:0] LEN_RET_INT = 4'hA;
    localparam logic [3:0] LEN_SW_TRAP = 4'hC;
    localparam logic [3:0] LEN_BRANCH = 4'h4;
    localparam logic [3:0] LEN_BR_CALL = 4'h8;
    localparam logic [3:0] LEN_RMW_EXT = 4'h6;
    localparam logic [3:0] LEN_IRQ = 4'hC;
    localparam logic [3:0] LEN_IRQ_SHORT = 4'h4;

    localparam logic [15:0] SWI_VECTOR = 16'hFFFA;
    localparam logic [15:0] IRQ_VECTOR_DEFAULT = 16'hFFF8;
    localparam logic [15:0] RESET_ADDR = 16'h0000;
    localparam logic [3:0] FIRST_CYCLE = 4'h1;
    localparam logic [3:0] PUSH_FIRST = 4'h3; // first of the seven pushes

endpackage

// File: src/cbs_sequencer.sv
`timescale 1ns/1ps
// Function
// - extended 16-bit store: 6 cycles, dead cycle, high byte then low
// - extended call: 9 cycles, target fetch, push return low then high
// - extended call cycles 7,8 strobe low, cycle 9 rereads opcode+2
// - two-cycle inherent: opcode then next opcode at address plus one
// - pull: 4 cycles, dead cycle at stack, read stack plus one
// - subroutine return: 5 cycles, ignored read, dead cycle, two pops
// - wait: 9 cycles, seven pushes to decreasing stack addresses
// - interrupt return: 10 cycles, dead cycle, seven pops upward
// - software trap: 12 cycles, seven pushes, dead cycle, FFFA, FFFB
// - relative branch: 4 cycles, two strobe-low cycles
// - branch call: 8 cycles, dead cycle, two pushes, idle cycles
// - don't-care read data is discarded by the processor
// - test in modify mode: last cycle strobe low, operand unchanged
// - interrupt entry 12 cycles, only 4 after a wait
module cbs_sequencer #(
    parameter logic [15:0] IRQ_VECTOR = cbs_pkg::IRQ_VECTOR_DEFAULT
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire cbs_pkg::cbs_class_t opClass,
    input wire logic testOp,
    input wire cbs_pkg::cbs_addrs_t addrs,
    input wire logic irqReq,
    output logic [15:0] busAddr,
    output logic validAddressStrobe,
    output logic readNotWrite,
    output cbs_pkg::cbs_src_t dataSrc,
    output logic dataTake,
    output logic [3:0] cycleNum,
    output logic busy,
    output logic done,
    output logic irqTaken
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } cbs_state_t;

    cbs_state_t state;
    cbs_pkg::cbs_class_t curClass;
    cbs_pkg::cbs_addrs_t curAddrs;
    logic curTest;
    logic [3:0] cycle;
    logic [3:0] curLen;
    logic registersStacked;
    logic launch;
    cbs_pkg::cbs_class_t launchClass;
    logic [3:0] next_cycle;
    cbs_pkg::cbs_class_t stepClass;
    cbs_pkg::cbs_addrs_t stepAddrs;
    logic stepTest;
    cbs_pkg::cbs_cycle_t step;
    logic [15:0] baseAddr;

    // build one cycle entry
    function automatic cbs_pkg::cbs_cycle_t mk(
        input logic valid_address_strobe,
        input logic rdnwr,
        input cbs_pkg::cbs_base_t base,
        input logic down,
        input logic [3:0] off,
        input cbs_pkg::cbs_src_t src,
        input logic take
    );
        cbs_pkg::cbs_cycle_t c;
        c.valid_address_strobe = valid_address_strobe;
        c.readNotWrite = rdnwr;
        c.base = base;
        c.down = down;
        c.offset = off;
        c.src = src;
        c.take = take;
        return c;
    endfunction

    // meaningful read from the opcode stream
    function automatic cbs_pkg::cbs_cycle_t fetch(input logic [3:0] off);
        return mk(1'b1, 1'b1, cbs_pkg::BASE_OPCODE, 1'b0, off,
            cbs_pkg::SRC_NONE, 1'b1);
    endfunction

    // strobe-low cycle, data floats and is discarded
    function automatic cbs_pkg::cbs_cycle_t dead(
        input cbs_pkg::cbs_base_t base,
        input logic down,
        input logic [3:0] off
    );
        return mk(1'b0, 1'b1, base, down, off, cbs_pkg::SRC_NONE, 1'b0);
    endfunction

    // write to stack pointer minus offset
    function automatic cbs_pkg::cbs_cycle_t push(
        input logic [3:0] off,
        input cbs_pkg::cbs_src_t src
    );
        return mk(1'b1, 1'b0, cbs_pkg::BASE_STACK, 1'b1, off, src, 1'b0);
    endfunction

    // read from stack pointer plus offset
    function automatic cbs_pkg::cbs_cycle_t pop(input logic [3:0] off);
        return mk(1'b1, 1'b1, cbs_pkg::BASE_STACK, 1'b0, off,
            cbs_pkg::SRC_NONE, 1'b1);
    endfunction

    // seven-byte register stacking shared by wait, trap and interrupt
    function automatic cbs_pkg::cbs_cycle_t stackAll(input logic [3:0] n);
        cbs_pkg::cbs_src_t s;
        logic [3:0] k;
        k = n - cbs_pkg::PUSH_FIRST;
        unique case (k)
            4'h0: s = cbs_pkg::SRC_RET_LO;
            4'h1: s = cbs_pkg::SRC_RET_HI;
            4'h2: s = cbs_pkg::SRC_IDX_LO;
            4'h3: s = cbs_pkg::SRC_IDX_HI;
            4'h4: s = cbs_pkg::SRC_ACC_A;
            4'h5: s = cbs_pkg::SRC_ACC_B;
            default: s = cbs_pkg::SRC_CCR;
        endcase
        return push(k, s);
    endfunction

    // cycle table, n counts from one
    function automatic cbs_pkg::cbs_cycle_t table_step(
        input cbs_pkg::cbs_class_t cls,
        input logic [3:0] n,
        input logic tst
    );
        cbs_pkg::cbs_cycle_t c;
        c = fetch(4'h0);
        unique case (cls)
            cbs_pkg::CLS_STORE16_EXT: begin
                if (n == 4'h4) c = dead(cbs_pkg::BASE_OPERAND, 1'b0, 4'h0);
                else if (n == 4'h5) c = mk(1'b1, 1'b0,
                    cbs_pkg::BASE_OPERAND, 1'b0, 4'h0,
                    cbs_pkg::SRC_REG_HI, 1'b0);
                else if (n == 4'h6) c = mk(1'b1, 1'b0,
                    cbs_pkg::BASE_OPERAND, 1'b0, 4'h1,
                    cbs_pkg::SRC_REG_LO, 1'b0);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_CALL_EXT: begin
                if (n == 4'h4) c = mk(1'b1, 1'b1, cbs_pkg::BASE_BRANCH,
                    1'b0, 4'h0, cbs_pkg::SRC_NONE, 1'b1);
                else if (n == 4'h5) c = push(4'h0, cbs_pkg::SRC_RET_LO);
                else if (n == 4'h6) c = push(4'h1, cbs_pkg::SRC_RET_HI);
                else if (n == 4'h7) c = dead(cbs_pkg::BASE_STACK, 1'b1,
                    4'h2);
                else if (n == 4'h8) c = dead(cbs_pkg::BASE_OPCODE, 1'b0,
                    4'h2);
                else if (n == 4'h9) c = fetch(4'h2);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_INHERENT2: begin
                c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_PULL: begin
                if (n == 4'h3) c = dead(cbs_pkg::BASE_STACK, 1'b0, 4'h0);
                else if (n == 4'h4) c = pop(4'h1);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_RET_SUB, cbs_pkg::CLS_RET_INT: begin
                if (n == 4'h2) c = mk(1'b1, 1'b1, cbs_pkg::BASE_OPCODE,
                    1'b0, 4'h1, cbs_pkg::SRC_NONE, 1'b0);
                else if (n == 4'h3) c = dead(cbs_pkg::BASE_STACK, 1'b0,
                    4'h0);
                else if (n > 4'h3) c = pop(n - 4'h3);
            end
            cbs_pkg::CLS_WAIT: begin
                if (n >= cbs_pkg::PUSH_FIRST) c = stackAll(n);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_SW_TRAP, cbs_pkg::CLS_IRQ: begin
                if (n <= 4'h2 && cls == cbs_pkg::CLS_SW_TRAP)
                    c = mk(1'b1, 1'b1, cbs_pkg::BASE_OPCODE, 1'b0, n - 4'h1,
                        cbs_pkg::SRC_NONE, n == 4'h1);
                else if (n <= 4'h2) c = dead(cbs_pkg::BASE_OPCODE, 1'b0,
                    4'h0);
                else if (n <= 4'h9) c = stackAll(n);
                else if (n == 4'hA) c = dead(cbs_pkg::BASE_STACK, 1'b1,
                    4'h7);
                else c = mk(1'b1, 1'b1,
                    (cls == cbs_pkg::CLS_SW_TRAP) ? cbs_pkg::BASE_SWI_VEC :
                    cbs_pkg::BASE_IRQ_VEC, 1'b0, n - 4'hB,
                    cbs_pkg::SRC_NONE, 1'b1);
            end
            cbs_pkg::CLS_IRQ_SHORT: begin
                if (n <= 4'h2) c = dead(cbs_pkg::BASE_STACK, 1'b1, 4'h7);
                else c = mk(1'b1, 1'b1, cbs_pkg::BASE_IRQ_VEC, 1'b0,
                    n - 4'h3, cbs_pkg::SRC_NONE, 1'b1);
            end
            cbs_pkg::CLS_BRANCH: begin
                if (n == 4'h3) c = dead(cbs_pkg::BASE_OPCODE, 1'b0, 4'h2);
                else if (n == 4'h4) c = dead(cbs_pkg::BASE_BRANCH, 1'b0,
                    4'h0);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_BR_CALL: begin
                if (n == 4'h3 || n == 4'h7) c = dead(cbs_pkg::BASE_OPCODE,
                    1'b0, 4'h2);
                else if (n == 4'h4) c = push(4'h0, cbs_pkg::SRC_RET_LO);
                else if (n == 4'h5) c = push(4'h1, cbs_pkg::SRC_RET_HI);
                else if (n == 4'h6) c = dead(cbs_pkg::BASE_STACK, 1'b1,
                    4'h2);
                else if (n == 4'h8) c = dead(cbs_pkg::BASE_BRANCH, 1'b0,
                    4'h0);
                else c = fetch(n - 4'h1);
            end
            cbs_pkg::CLS_RMW_EXT: begin
                if (n == 4'h4) c = mk(1'b1, 1'b1, cbs_pkg::BASE_OPERAND,
                    1'b0, 4'h0, cbs_pkg::SRC_NONE, 1'b1);
                else if (n == 4'h5) c = dead(cbs_pkg::BASE_OPERAND, 1'b0,
                    4'h0);
                else if (n == 4'h6) c = mk(!tst, 1'b0,
                    cbs_pkg::BASE_OPERAND, 1'b0, 4'h0,
                    tst ? cbs_pkg::SRC_NONE : cbs_pkg::SRC_NEW_OPERAND,
                    1'b0);
                else c = fetch(n - 4'h1);
            end
            default: c = dead(cbs_pkg::BASE_OPCODE, 1'b0, 4'h0);
        endcase
        return c;
    endfunction

    // cycle count per class
    function automatic logic [3:0] class_len(input cbs_pkg::cbs_class_t cls);
        unique case (cls)
            cbs_pkg::CLS_STORE16_EXT: return cbs_pkg::LEN_STORE16_EXT;
            cbs_pkg::CLS_CALL_EXT: return cbs_pkg::LEN_CALL_EXT;
            cbs_pkg::CLS_INHERENT2: return cbs_pkg::LEN_INHERENT2;
            cbs_pkg::CLS_PULL: return cbs_pkg::LEN_PULL;
            cbs_pkg::CLS_RET_SUB: return cbs_pkg::LEN_RET_SUB;
            cbs_pkg::CLS_WAIT: return cbs_pkg::LEN_WAIT;
            cbs_pkg::CLS_RET_INT: return cbs_pkg::LEN_RET_INT;
            cbs_pkg::CLS_SW_TRAP: return cbs_pkg::LEN_SW_TRAP;
            cbs_pkg::CLS_BRANCH: return cbs_pkg::LEN_BRANCH;
            cbs_pkg::CLS_BR_CALL: return cbs_pkg::LEN_BR_CALL;
            cbs_pkg::CLS_RMW_EXT: return cbs_pkg::LEN_RMW_EXT;
            cbs_pkg::CLS_IRQ: return cbs_pkg::LEN_IRQ;
            cbs_pkg::CLS_IRQ_SHORT: return cbs_pkg::LEN_IRQ_SHORT;
            default: return cbs_pkg::LEN_INHERENT2;
        endcase
    endfunction

    // launch when idle or on the last cycle; interrupt beats a new opcode
    always_comb begin
        launch = (state == ST_IDLE || done) && (start || irqReq);
        if (irqReq)
            launchClass = (done ? curClass == cbs_pkg::CLS_WAIT ||
                (registersStacked && curClass != cbs_pkg::CLS_IRQ_SHORT) :
                registersStacked) ? cbs_pkg::CLS_IRQ_SHORT :
                cbs_pkg::CLS_IRQ;
        else
            launchClass = opClass;
        next_cycle = launch ? cbs_pkg::FIRST_CYCLE : cycle + 4'h1;
        stepClass = launch ? launchClass : curClass;
        stepAddrs = launch ? addrs : curAddrs;
        stepTest = launch ? testOp : curTest;
        step = table_step(stepClass, next_cycle, stepTest);
        unique case (step.base)
            cbs_pkg::BASE_OPCODE: baseAddr = stepAddrs.opcodeAddr;
            cbs_pkg::BASE_OPERAND: baseAddr = stepAddrs.operandAddr;
            cbs_pkg::BASE_STACK: baseAddr = stepAddrs.stackPtr;
            cbs_pkg::BASE_BRANCH: baseAddr = stepAddrs.branchAddr;
            cbs_pkg::BASE_SWI_VEC: baseAddr = cbs_pkg::SWI_VECTOR;
            cbs_pkg::BASE_IRQ_VEC: baseAddr = IRQ_VECTOR;
            default: baseAddr = stepAddrs.opcodeAddr;
        endcase
    end

    // sequence state, class and operand latch
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            cycle <= 4'h0;
            curLen <= 4'h0;
            curClass <= cbs_pkg::CLS_INHERENT2;
            curAddrs <= '0;
            curTest <= 1'b0;
        end else if (launch) begin
            state <= ST_RUN;
            cycle <= cbs_pkg::FIRST_CYCLE;
            curLen <= class_len(launchClass);
            curClass <= launchClass;
            curAddrs <= addrs;
            curTest <= testOp;
        end else if (done) begin
            state <= ST_IDLE;
            cycle <= 4'h0;
        end else if (state == ST_RUN) begin
            cycle <= next_cycle;
        end
    end

    // wait leaves registers stacked until the interrupt entry ends
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            registersStacked <= 1'b0;
        else if (done && curClass == cbs_pkg::CLS_WAIT)
            registersStacked <= 1'b1;
        else if (done && curClass == cbs_pkg::CLS_IRQ_SHORT)
            registersStacked <= 1'b0;
    end

    // registered bus outputs; idle shows a dead read cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst || (done && !launch)) begin
            busAddr <= cbs_pkg::RESET_ADDR;
            validAddressStrobe <= 1'b0;
            readNotWrite <= 1'b1;
            dataSrc <= cbs_pkg::SRC_NONE;
            dataTake <= 1'b0;
        end else if (launch || state == ST_RUN) begin
            busAddr <= step.down ? baseAddr - {12'h000, step.offset} :
                baseAddr + {12'h000, step.offset};
            validAddressStrobe <= step.valid_address_strobe;
            readNotWrite <= step.readNotWrite;
            dataSrc <= step.src;
            dataTake <= step.take && step.valid_address_strobe;
        end
    end

    assign busy = (state == ST_RUN);
    assign done = (state == ST_RUN) && (cycle == curLen);
    assign cycleNum = cycle;
    assign irqTaken = launch && irqReq;

endmodule

// File: test/cbs_sequencer_asserts.sv
`timescale 1ns/1ps
module cbs_sequencer_asserts (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire cbs_pkg::cbs_class_t opClass,
    input wire logic testOp,
    input wire logic irqReq,
    input wire logic [15:0] busAddr,
    input wire logic validAddressStrobe,
    input wire logic readNotWrite,
    input wire cbs_pkg::cbs_src_t dataSrc,
    input wire logic dataTake,
    input wire logic [3:0] cycleNum,
    input wire logic busy,
    input wire logic done,
    input wire logic irqTaken
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a start request the sequencer must launch
    wire go = start && !irqReq && (!busy || done);
    // strobed write cycle
    sequence wr_s;
        validAddressStrobe && !readNotWrite;
    endsequence
    // dead cycle with nothing taken
    sequence dead_s;
        !validAddressStrobe && !dataTake;
    endsequence
    store_order_a: assert property (
        go && opClass == cbs_pkg::CLS_STORE16_EXT
        |=> ##3 dead_s ##1 wr_s ##1 wr_s ##0 done)
        else $error("store cycle pattern wrong");
    call_stack_a: assert property (
        go && opClass == cbs_pkg::CLS_CALL_EXT |=> ##4 wr_s ##1 wr_s
        ##1 dead_s[*2] ##1 (validAddressStrobe && readNotWrite && done))
        else $error("call cycle pattern wrong");
    wait_push_a: assert property (
        go && opClass == cbs_pkg::CLS_WAIT |=> ##2 wr_s[*7] ##0 done)
        else $error("wait pushes wrong");
    int_return_a: assert property (
        go && opClass == cbs_pkg::CLS_RET_INT |=> ##2 dead_s
        ##1 (validAddressStrobe && readNotWrite && dataTake)[*7] ##0 done)
        else $error("interrupt return pops wrong");
    trap_vector_a: assert property (
        go && opClass == cbs_pkg::CLS_SW_TRAP |=> ##10 busAddr == 16'hFFFA
        ##1 (busAddr == 16'hFFFB && done))
        else $error("trap vector fetch wrong");
    branch_dead_a: assert property (
        go && opClass == cbs_pkg::CLS_BRANCH |=> ##2 dead_s[*2] ##0 done)
        else $error("branch dead cycles wrong");
    test_keep_a: assert property (
        go && opClass == cbs_pkg::CLS_RMW_EXT && testOp |=> ##5
        (!validAddressStrobe && done && dataSrc == cbs_pkg::SRC_NONE))
        else $error("test op touched the operand");
    dead_quiet_a: assert property (
        !validAddressStrobe |-> !dataTake && dataSrc == cbs_pkg::SRC_NONE)
        else $error("data used in a dead cycle");
    write_src_a: assert property (
        wr_s |-> dataSrc != cbs_pkg::SRC_NONE && !dataTake)
        else $error("write cycle without source");
    irq_first_a: assert property (
        irqReq && (!busy || done) |-> irqTaken
        ##1 (cycleNum == 4'h1 && !validAddressStrobe))
        else $error("interrupt launch wrong");
endmodule
bind cbs_sequencer cbs_sequencer_asserts i_cbs_sequencer_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .start(start),
    .opClass(opClass), .testOp(testOp), .irqReq(irqReq),
    .busAddr(busAddr), .validAddressStrobe(validAddressStrobe),
    .readNotWrite(readNotWrite), .dataSrc(dataSrc), .dataTake(dataTake),
    .cycleNum(cycleNum), .busy(busy), .done(done), .irqTaken(irqTaken));

// File: test/cbs_bus_memory.sv
`timescale 1ns/1ps
module cbs_bus_memory (
    input wire logic core_clk,
    input wire logic [15:0] busAddr,
    input wire logic validAddressStrobe,
    input wire logic readNotWrite,
    output logic [7:0] readData
);
    logic [7:0] lastData = 8'h5A;
    // answer strobed reads only; a floating bus shows a changing value
    always_comb begin
        if (validAddressStrobe && readNotWrite) begin
            readData = busAddr[7:0] ^ busAddr[15:8];
        end else begin
            readData = ~lastData;
        end
    end
    // last value seen on the bus
    always_ff @(posedge core_clk) begin
        lastData <= readData;
    end
endmodule

// File: test/cbs_sequencer_test.sv
`timescale 1ns/1ps
module cbs_sequencer_test;
    typedef struct packed {
        logic [15:0] addr;
        logic valid_address_strobe;
        logic rnw;
        cbs_pkg::cbs_src_t src;
        logic take;
        logic [3:0] num;
        logic last;
    } cbs_exp_t;
    localparam logic [15:0] IRQV = 16'hFFF8;
    localparam cbs_pkg::cbs_src_t NO = cbs_pkg::SRC_NONE;
    localparam cbs_exp_t IDLE = '{16'h0000, 1'b0, 1'b1, NO, 1'b0, 4'h0, 1'b0};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic testOp = 1'b0;
    logic irqReq = 1'b0;
    logic stk = 1'b0;
    cbs_pkg::cbs_class_t opClass = cbs_pkg::CLS_INHERENT2;
    cbs_pkg::cbs_addrs_t addrs = '0;
    cbs_pkg::cbs_addrs_t a, waitA;
    cbs_pkg::cbs_src_t dataSrc;
    logic [15:0] busAddr, o, od, sp, br;
    logic [3:0] cycleNum;
    logic [7:0] readData;
    logic validAddressStrobe, readNotWrite, dataTake, busy, done, irqTaken;
    cbs_exp_t expQ[$];
    int err_total = 0;
    int checks = 0;
    int nCyc = 0;
    cbs_sequencer #(.IRQ_VECTOR(IRQV)) i_cbs_sequencer (
        .core_clk(core_clk), .sys_rst(sys_rst), .start(start),
        .opClass(opClass), .testOp(testOp), .addrs(addrs), .irqReq(irqReq),
        .busAddr(busAddr), .validAddressStrobe(validAddressStrobe),
        .readNotWrite(readNotWrite), .dataSrc(dataSrc), .dataTake(dataTake),
        .cycleNum(cycleNum), .busy(busy), .done(done), .irqTaken(irqTaken));
    cbs_bus_memory i_cbs_bus_memory (.core_clk(core_clk), .busAddr(busAddr),
        .validAddressStrobe(validAddressStrobe),
        .readNotWrite(readNotWrite), .readData(readData));
    always #5 core_clk = ~core_clk;
    task automatic chk(input cbs_exp_t s, input cbs_exp_t e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // note one expected bus cycle
    task automatic cyc(input logic [15:0] ad, input logic v, input logic r,
                       input cbs_pkg::cbs_src_t s, input logic tk);
        nCyc++;
        expQ.push_back('{ad, v, r, s, tk, 4'(nCyc), 1'b0});
    endtask
    task automatic push7();
        for (int i = 0; i < 7; i++)
            cyc(sp - 16'(i), 1'b1, 1'b0, cbs_pkg::cbs_src_t'(4'(i + 1)), 1'b0);
    endtask
    // expected cycles of one instruction class
    task automatic build(input cbs_pkg::cbs_class_t c, input logic t);
        nCyc = 0;
        if (c < cbs_pkg::CLS_IRQ) begin
            cyc(o, 1'b1, 1'b1, NO, 1'b1);
            cyc(o + 16'h1, 1'b1, 1'b1, NO, !(c inside {cbs_pkg::CLS_RET_SUB,
                cbs_pkg::CLS_RET_INT, cbs_pkg::CLS_SW_TRAP}));
            if (c inside {cbs_pkg::CLS_STORE16_EXT, cbs_pkg::CLS_CALL_EXT,
                cbs_pkg::CLS_RMW_EXT}) cyc(o + 16'h2, 1'b1, 1'b1, NO, 1'b1);
        end
        case (c)
            cbs_pkg::CLS_STORE16_EXT: begin
                cyc(od, 1'b0, 1'b1, NO, 1'b0);
                cyc(od, 1'b1, 1'b0, cbs_pkg::SRC_REG_HI, 1'b0);
                cyc(od + 16'h1, 1'b1, 1'b0, cbs_pkg::SRC_REG_LO, 1'b0);
            end
            cbs_pkg::CLS_CALL_EXT, cbs_pkg::CLS_BR_CALL: begin
                if (c == cbs_pkg::CLS_CALL_EXT) cyc(br, 1'b1, 1'b1, NO, 1'b1);
                else cyc(o + 16'h2, 1'b0, 1'b1, NO, 1'b0);
                cyc(sp, 1'b1, 1'b0, cbs_pkg::SRC_RET_LO, 1'b0);
                cyc(sp - 16'h1, 1'b1, 1'b0, cbs_pkg::SRC_RET_HI, 1'b0);
                cyc(sp - 16'h2, 1'b0, 1'b1, NO, 1'b0);
                cyc(o + 16'h2, 1'b0, 1'b1, NO, 1'b0);
                if (c == cbs_pkg::CLS_CALL_EXT) cyc(o + 16'h2, 1, 1, NO, 1);
                else cyc(br, 1'b0, 1'b1, NO, 1'b0);
            end
            cbs_pkg::CLS_PULL, cbs_pkg::CLS_RET_SUB: begin
                cyc(sp, 1'b0, 1'b1, NO, 1'b0);
                cyc(sp + 16'h1, 1'b1, 1'b1, NO, 1'b1);
                if (c == cbs_pkg::CLS_RET_SUB) cyc(sp + 16'h2, 1, 1, NO, 1);
            end
            cbs_pkg::CLS_WAIT: begin
                push7();
                stk = 1'b1;
                waitA = a;
            end
            cbs_pkg::CLS_RET_INT: begin
                cyc(sp, 1'b0, 1'b1, NO, 1'b0);
                for (int i = 1; i < 8; i++) cyc(sp + 16'(i), 1, 1, NO, 1);
            end
            cbs_pkg::CLS_SW_TRAP, cbs_pkg::CLS_IRQ: begin
                if (c == cbs_pkg::CLS_IRQ) cyc(o, 1'b0, 1'b1, NO, 1'b0);
                if (c == cbs_pkg::CLS_IRQ) cyc(o, 1'b0, 1'b1, NO, 1'b0);
                push7();
                cyc(sp - 16'h7, 1'b0, 1'b1, NO, 1'b0);
                cyc(c == cbs_pkg::CLS_IRQ ? IRQV : 16'hFFFA, 1, 1, NO, 1);
                cyc(c == cbs_pkg::CLS_IRQ ? IRQV + 16'h1 : 16'hFFFB,
                    1, 1, NO, 1);
            end
            cbs_pkg::CLS_IRQ_SHORT: begin
                cyc(sp - 16'h7, 1'b0, 1'b1, NO, 1'b0);
                cyc(sp - 16'h7, 1'b0, 1'b1, NO, 1'b0);
                cyc(IRQV, 1'b1, 1'b1, NO, 1'b1);
                cyc(IRQV + 16'h1, 1'b1, 1'b1, NO, 1'b1);
                stk = 1'b0;
            end
            cbs_pkg::CLS_BRANCH: begin
                cyc(o + 16'h2, 1'b0, 1'b1, NO, 1'b0);
                cyc(br, 1'b0, 1'b1, NO, 1'b0);
            end
            cbs_pkg::CLS_RMW_EXT: begin
                cyc(od, 1'b1, 1'b1, NO, 1'b1);
                cyc(od, 1'b0, 1'b1, NO, 1'b0);
                cyc(od, !t, 1'b0, t ? NO : cbs_pkg::SRC_NEW_OPERAND, 1'b0);
            end
            default: ;
        endcase
        expQ[expQ.size() - 1].last = 1'b1;
    endtask
    // request an instruction and wait for its last cycle
    task automatic run(input cbs_pkg::cbs_class_t c, input logic t,
                       input logic irq);
        int k;
        if (irq && stk) a = waitA;
        else a = {$urandom, $urandom};
        {o, od, sp, br} = a;
        build(irq ? (stk ? cbs_pkg::CLS_IRQ_SHORT : cbs_pkg::CLS_IRQ) : c, t);
        addrs = a;
        opClass = c;
        testOp = t;
        start = 1'b1;
        irqReq = irq;
        #1 chk(cbs_exp_t'(28'(irqTaken)), cbs_exp_t'(28'(irq)));
        @(negedge core_clk);
        irqReq = 1'b0;
        opClass = cbs_pkg::cbs_class_t'(4'($urandom_range(10)));
        addrs = {$urandom, $urandom};
        for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge core_clk);
    endtask
    task automatic gap(input int k);
        start = 1'b0;
        irqReq = 1'b0;
        repeat (k) @(negedge core_clk);
    endtask
    // compare every cycle against the oldest note, idle when none runs
    always @(negedge core_clk) begin
        if (sys_rst === 1'b0) begin
            if (busy === 1'b1 && expQ.size() > 0)
                chk({busAddr, validAddressStrobe, readNotWrite, dataSrc,
                     dataTake, cycleNum, done}, expQ.pop_front());
            else
                chk({busAddr, validAddressStrobe, readNotWrite, dataSrc,
                     dataTake, cycleNum, done}, IDLE);
        end
    end
    task automatic close_out();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        close_out();
    end
    initial begin
        logic irq;
        void'($urandom(53144));
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        gap(2);
        // all classes back to back, test form last, then short and full irq
        for (int c = 0; c <= 10; c++) run(cbs_pkg::cbs_class_t'(4'(c)), 0, 0);
        run(cbs_pkg::CLS_RMW_EXT, 1'b1, 1'b0);
        gap(1);
        run(cbs_pkg::CLS_PULL, 1'b0, 1'b1);
        gap(1);
        run(cbs_pkg::CLS_PULL, 1'b0, 1'b1);
        repeat (40) begin
            irq = $urandom_range(5) == 0;
            if ($urandom_range(1) == 1) gap(1 + $urandom_range(2));
            run(cbs_pkg::cbs_class_t'(4'($urandom_range(10))),
                1'($urandom), irq);
        end
        // reset in mid wait clears the stacked state
        gap(1);
        run(cbs_pkg::CLS_WAIT, 1'b0, 1'b0);
        gap(1);
        build(cbs_pkg::CLS_WAIT, 1'b0);
        addrs = a;
        start = 1'b1;
        opClass = cbs_pkg::CLS_WAIT;
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b1;
        start = 1'b0;
        stk = 1'b0;
        @(negedge core_clk);
        expQ.delete();
        @(negedge core_clk);
        sys_rst = 1'b0;
        gap(1);
        run(cbs_pkg::CLS_PULL, 1'b0, 1'b1);
        gap(2);
        close_out();
    end
endmodule
